// ---- hdl/brf_consts.svh ----
/*
 Constants for the barometer interrupt, FIFO control and reference register slice:
 register offsets, field positions, reset values and fixed counts.
 Assumes it is included by bare name from design files that need these values.
*/
`ifndef BRF_CONSTS_SVH
`define BRF_CONSTS_SVH

// Register offsets on the byte register port
`define BRF_OFS_IRQ_PIN_CONTROL   8'h12
`define BRF_OFS_FIFO_CONTROL      8'h14
`define BRF_OFS_REF_LOW           8'h15
`define BRF_OFS_REF_MID           8'h16
`define BRF_OFS_REF_HIGH          8'h17
`define BRF_OFS_OFFSET_LOW        8'h18
`define BRF_OFS_OFFSET_HIGH       8'h19
`define BRF_OFS_LOW_POWER_CONFIG  8'h1A
`define BRF_OFS_IRQ_SOURCE_FLAGS  8'h25

// Fields of irq_pin_control
`define BRF_BIT_ACTIVE_LOW        7
`define BRF_BIT_OPEN_DRAIN        6
`define BRF_BIT_FULL_EN           5
`define BRF_BIT_WATERMARK_EN      4
`define BRF_BIT_OVERRUN_EN        3
`define BRF_BIT_DATA_READY_EN     2
`define BRF_PIN_SRC_HI            1
`define BRF_PIN_SRC_LO            0

// Fields of fifo_control
`define BRF_FIFO_MODE_HI          7
`define BRF_FIFO_MODE_LO          5
`define BRF_WATERMARK_HI          4
`define BRF_WATERMARK_LO          0

// Fields of low_power_config and irq_source_flags
`define BRF_BIT_LOW_CURRENT       0
`define BRF_BIT_BOOT_STATUS       7
`define BRF_BIT_IRQ_ACTIVE        2
`define BRF_BIT_DIFF_LOW          1
`define BRF_BIT_DIFF_HIGH         0

// Reset values
`define BRF_RST_IRQ_PIN_CONTROL   8'h00
`define BRF_RST_FIFO_CONTROL      8'h00
`define BRF_RST_BYTE              8'h00
`define BRF_RST_LOW_POWER_CONFIG  8'h00

// FIFO depth and level count at full
`define BRF_FIFO_DEPTH            32
`define BRF_FIFO_FULL_COUNT       6'h20

// Pressure offset scale: the offset is shifted left by this many bits (times 256)
`define BRF_OFFSET_SHIFT          8

`endif

// ---- hdl/brf_pkg.sv ----
/*
 Types for the barometer register slice: FIFO modes and pin source selections.
 Assumes brf_consts.svh holds the numeric constants.
*/
package brf_pkg;

   // Buffering modes held in fifo_control
   typedef enum logic [2:0]
   {
      BRF_MODE_BYPASS           = 3'h0,
      BRF_MODE_FIFO             = 3'h1,
      BRF_MODE_STREAM           = 3'h2,
      BRF_MODE_STREAM_TO_FIFO   = 3'h3,
      BRF_MODE_BYPASS_TO_STREAM = 3'h4,
      BRF_MODE_RESERVED         = 3'h5,
      BRF_MODE_DYNAMIC_STREAM   = 3'h6,
      BRF_MODE_BYPASS_TO_FIFO   = 3'h7
   } brf_fifo_mode_t;

   // What drives the interrupt pin
   typedef enum logic [1:0]
   {
      BRF_SRC_DATA       = 2'h0,
      BRF_SRC_PRESS_HIGH = 2'h1,
      BRF_SRC_PRESS_LOW  = 2'h2,
      BRF_SRC_PRESS_ANY  = 2'h3
   } brf_pin_src_t;

endpackage : brf_pkg

// ---- hdl/brf_irq_pad.sv ----
/*
 Interrupt pad driver: turns the selected event into a pin level and an
 output enable, for push-pull or open-drain drive and either polarity.
 Assumes the pad cell or bench resolves the wire; enable is low while driving.
*/
`timescale 1ns/1ps
`include "brf_consts.svh"

module brf_irq_pad
(
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic event_level,
   input  wire logic active_low,
   input  wire logic open_drain,
   output logic      pin_o,
   output logic      pin_oe_n
);

   logic asserted_level;

   // Level the pin shows when the event is asserted
   assign asserted_level = ~active_low;

   // Registered pin drive; reset shows the idle level of active-high push-pull
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_o    <= 1'b0;
         pin_oe_n <= 1'b0;
      end
      else
      begin
         pin_o    <= event_level ? asserted_level : ~asserted_level;
         pin_oe_n <= open_drain & ~event_level;                      // Release when idle in open-drain only
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   a_pad_polarity: assert property (
      ##1 pin_o == ($past(event_level) ^ $past(active_low)))
      else $error("Pin level does not follow event and polarity");

   a_pad_drive: assert property (
      (!open_drain || event_level) |=> !pin_oe_n)
      else $error("Pad not driven when it must be");

   a_pad_release: assert property (
      (open_drain && !event_level) |=> pin_oe_n)
      else $error("Open-drain pad driven while idle");

endmodule : brf_irq_pad

// ---- hdl/brf_regs.sv ----
/*
 Register slice of the barometer: interrupt pin control, FIFO control,
 reference pressure, pressure offset, low-power configuration and the
 interrupt source flags, with the pin routing and offset subtraction.
 Assumes a serial interface core on the same clock that presents byte
 accesses as one-cycle strobes, and a sensor core on the same clock that
 provides FIFO level, events and the measured pressure.
*/
`timescale 1ns/1ps
`include "brf_consts.svh"

// Operation
// - Polarity bit 0 high, 1 low; resets 0
// - Drive bit 0 push-pull, 1 open-drain
// - Full enable routes FIFO full to pin; here only while data-ready, watermark and overrun enables are clear
// - Watermark enable routes threshold status to pin; here only while data-ready enable is clear
// - Overrun enable routes overrun to pin; here only while data-ready and watermark enables are clear
// - Data-ready enable routes data-ready to pin
// - Source field selects data, high, low, either
// - FIFO mode field bits 7:5, resets 000
// - Watermark level from bits 4:0
// - Reference is 24 bits over 15h..17h
// - Reference used when auto-zero or auto-reference on
// - Output is pressure minus 256 times offset; here only with diff_irq_en, auto_zero_en and auto_ref_en all off
// - Offset is 16 bits at 18h, 19h
// - Low-current bit selects low-current mode
// - Low-current applies to single-shot and continuous
// - Bit 7 of flags shows reboot running
// - Interrupt-active flag set when events generated
// - Differential low and high event flags
// - FIFO full at 32 samples, count 100000
// - Threshold status when level at watermark or above
module brf_regs
   import brf_pkg::*;
#(
   parameter int LEVEL_W = 6,
   parameter int PRESS_W = 24
)
(
   input  wire logic               clock,
   input  wire logic               nrst,
   // Byte register port from the serial interface core
   input  wire logic [7:0]         reg_addr,
   input  wire logic               reg_wr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_rd,
   output logic      [7:0]         reg_rdata,
   output logic                    reg_rvalid,
   // Sensor core status
   input  wire logic [LEVEL_W-1:0] fifo_level_count,
   input  wire logic               fifo_overrun,
   input  wire logic               data_ready,
   input  wire logic               press_high_evt,
   input  wire logic               press_low_evt,
   input  wire logic               boot_running,
   input  wire logic               diff_irq_en,
   input  wire logic               auto_zero_en,
   input  wire logic               auto_ref_en,
   input  wire logic [PRESS_W-1:0] measured_pressure,
   // Configuration towards the sensor core
   output brf_fifo_mode_t          fifo_mode,
   output logic      [4:0]         watermark_level,
   output logic                    fifo_threshold_status,
   output logic                    fifo_full,
   output logic      [PRESS_W-1:0] ref_pressure_value,
   output logic                    use_reference,
   output logic      [PRESS_W-1:0] pressure_out,
   output logic                    low_current_en,
   // Interrupt pin
   output logic                    irq_pin_o,
   output logic                    irq_pin_oe_n
);

   logic [7:0]         irq_pin_control;
   logic [7:0]         fifo_control;
   logic [7:0]         reference_pressure_low;
   logic [7:0]         reference_pressure_mid;
   logic [7:0]         reference_pressure_high;
   logic [7:0]         pressure_offset_low;
   logic [7:0]         pressure_offset_high;
   logic [7:0]         low_power_config;
   logic               diff_low_flag;
   logic               diff_high_flag;
   logic               irq_active_flag;
   logic               flags_read;
   logic [15:0]        pressure_offset_value;
   logic [PRESS_W-1:0] offset_scaled;
   logic               next_threshold;
   logic               next_full;
   logic               data_event;
   logic               selected_event;
   logic [7:0]         next_rdata;
   brf_pin_src_t       pin_source;

   // Write strobes per register
   logic wr_pin_ctl;
   logic wr_fifo_ctl;
   logic wr_ref_low;
   logic wr_ref_mid;
   logic wr_ref_high;
   logic wr_ofs_low;
   logic wr_ofs_high;
   logic wr_low_power;

   assign wr_pin_ctl   = reg_wr && (reg_addr == `BRF_OFS_IRQ_PIN_CONTROL);
   assign wr_fifo_ctl  = reg_wr && (reg_addr == `BRF_OFS_FIFO_CONTROL);
   assign wr_ref_low   = reg_wr && (reg_addr == `BRF_OFS_REF_LOW);
   assign wr_ref_mid   = reg_wr && (reg_addr == `BRF_OFS_REF_MID);
   assign wr_ref_high  = reg_wr && (reg_addr == `BRF_OFS_REF_HIGH);
   assign wr_ofs_low   = reg_wr && (reg_addr == `BRF_OFS_OFFSET_LOW);
   assign wr_ofs_high  = reg_wr && (reg_addr == `BRF_OFS_OFFSET_HIGH);
   assign wr_low_power = reg_wr && (reg_addr == `BRF_OFS_LOW_POWER_CONFIG);
   assign flags_read   = reg_rd && (reg_addr == `BRF_OFS_IRQ_SOURCE_FLAGS);

   // Interrupt pin control register; fields steer the pin routing below
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         irq_pin_control <= `BRF_RST_IRQ_PIN_CONTROL;
      else if (wr_pin_ctl)
         irq_pin_control <= reg_wdata;
   end

   // FIFO control register: mode in the top three bits, watermark below
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         fifo_control <= `BRF_RST_FIFO_CONTROL;
      else if (wr_fifo_ctl)
         fifo_control <= reg_wdata;
   end

   // Reference pressure bytes, low byte at the lowest offset
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         reference_pressure_low  <= `BRF_RST_BYTE;
         reference_pressure_mid  <= `BRF_RST_BYTE;
         reference_pressure_high <= `BRF_RST_BYTE;
      end
      else
      begin
         if (wr_ref_low)
            reference_pressure_low <= reg_wdata;
         if (wr_ref_mid)
            reference_pressure_mid <= reg_wdata;
         if (wr_ref_high)
            reference_pressure_high <= reg_wdata;
      end
   end

   // Pressure offset bytes
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pressure_offset_low  <= `BRF_RST_BYTE;
         pressure_offset_high <= `BRF_RST_BYTE;
      end
      else
      begin
         if (wr_ofs_low)
            pressure_offset_low <= reg_wdata;
         if (wr_ofs_high)
            pressure_offset_high <= reg_wdata;
      end
   end

   // Low-power configuration; reserved bits are stored as written, the host keeps them legal
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         low_power_config <= `BRF_RST_LOW_POWER_CONFIG;
      else if (wr_low_power)
         low_power_config <= reg_wdata;
   end

   // One mode bit for every conversion kind: the core has no per-kind override
   assign low_current_en = low_power_config[`BRF_BIT_LOW_CURRENT];

   // Configuration fields seen by the sensor core
   assign fifo_mode          = brf_fifo_mode_t'(fifo_control[`BRF_FIFO_MODE_HI:`BRF_FIFO_MODE_LO]);
   assign watermark_level    = fifo_control[`BRF_WATERMARK_HI:`BRF_WATERMARK_LO];
   assign ref_pressure_value = {reference_pressure_high, reference_pressure_mid, reference_pressure_low};
   assign pin_source         = brf_pin_src_t'(irq_pin_control[`BRF_PIN_SRC_HI:`BRF_PIN_SRC_LO]);

   // FIFO status derived from the stored level
   assign next_threshold = ({1'b0, watermark_level} <= fifo_level_count);
   assign next_full      = (fifo_level_count == `BRF_FIFO_FULL_COUNT);

   // Registered FIFO status so the pin path starts from a flop
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         fifo_threshold_status <= 1'b0;
         fifo_full             <= 1'b0;
      end
      else
      begin
         fifo_threshold_status <= next_threshold;
         fifo_full             <= next_full;
      end
   end

   // Data signal: highest-priority enabled source wins, lower ones are masked
   always_comb
   begin
      if (irq_pin_control[`BRF_BIT_DATA_READY_EN])
         data_event = data_ready;
      else if (irq_pin_control[`BRF_BIT_WATERMARK_EN])
         data_event = fifo_threshold_status;
      else if (irq_pin_control[`BRF_BIT_OVERRUN_EN])
         data_event = fifo_overrun;
      else if (irq_pin_control[`BRF_BIT_FULL_EN])
         data_event = fifo_full;
      else
         data_event = 1'b0;
   end

   // Pin source selection
   always_comb
   begin
      case (pin_source)
         BRF_SRC_DATA:       selected_event = data_event;
         BRF_SRC_PRESS_HIGH: selected_event = press_high_evt;
         BRF_SRC_PRESS_LOW:  selected_event = press_low_evt;
         default:            selected_event = press_high_evt | press_low_evt;
      endcase
   end

   // Pad driver forms the level and enable from flops
   brf_irq_pad u_irq_pad
   (
      .clock       (clock),
      .nrst        (nrst),
      .event_level (selected_event),
      .active_low  (irq_pin_control[`BRF_BIT_ACTIVE_LOW]),
      .open_drain  (irq_pin_control[`BRF_BIT_OPEN_DRAIN]),
      .pin_o       (irq_pin_o),
      .pin_oe_n    (irq_pin_oe_n)
   );

   // Differential flags: sticky until the flag register is read; a new event wins over the clear
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         diff_low_flag  <= 1'b0;
         diff_high_flag <= 1'b0;
      end
      else
      begin
         if (press_low_evt)
            diff_low_flag <= 1'b1;
         else if (flags_read)
            diff_low_flag <= 1'b0;
         if (press_high_evt)
            diff_high_flag <= 1'b1;
         else if (flags_read)
            diff_high_flag <= 1'b0;
      end
   end

   // Interrupt-active: any high or low pressure event generated since the last read
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         irq_active_flag <= 1'b0;
      else if (press_low_evt || press_high_evt)
         irq_active_flag <= 1'b1;
      else if (flags_read)
         irq_active_flag <= 1'b0;
   end

   // Offset scaled by 256; upper bits beyond the output width drop off as in the core
   assign pressure_offset_value = {pressure_offset_high, pressure_offset_low};
   assign offset_scaled         = PRESS_W'({pressure_offset_value, 8'h00});

   // Pressure output; the differential paths belong to the core, so they pass raw pressure here
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pressure_out  <= '0;
         use_reference <= 1'b0;
      end
      else
      begin
         use_reference <= auto_zero_en | auto_ref_en;
         if (!diff_irq_en && !auto_zero_en && !auto_ref_en)
            pressure_out <= measured_pressure - offset_scaled;
         else
            pressure_out <= measured_pressure;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      if (reg_addr == `BRF_OFS_IRQ_PIN_CONTROL)
         next_rdata = irq_pin_control;
      else if (reg_addr == `BRF_OFS_FIFO_CONTROL)
         next_rdata = fifo_control;
      else if (reg_addr == `BRF_OFS_REF_LOW)
         next_rdata = reference_pressure_low;
      else if (reg_addr == `BRF_OFS_REF_MID)
         next_rdata = reference_pressure_mid;
      else if (reg_addr == `BRF_OFS_REF_HIGH)
         next_rdata = reference_pressure_high;
      else if (reg_addr == `BRF_OFS_OFFSET_LOW)
         next_rdata = pressure_offset_low;
      else if (reg_addr == `BRF_OFS_OFFSET_HIGH)
         next_rdata = pressure_offset_high;
      else if (reg_addr == `BRF_OFS_LOW_POWER_CONFIG)
         next_rdata = low_power_config;
      else if (reg_addr == `BRF_OFS_IRQ_SOURCE_FLAGS)
         next_rdata = {boot_running, 4'h0, irq_active_flag, diff_low_flag, diff_high_flag};
      else
         next_rdata = 8'h00;
   end

   // Read data stands one cycle after the strobe, then holds until the next read
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= next_rdata;
      end
   end

   // ---- Checks ----
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   a_pin_polarity: assert property (
      (pin_source == BRF_SRC_PRESS_HIGH && $stable(irq_pin_control)) ##1 $stable(irq_pin_control)
      |-> irq_pin_o == ($past(press_high_evt) ^ irq_pin_control[`BRF_BIT_ACTIVE_LOW]))
      else $error("Pin level does not follow high event and polarity");

   a_open_drain_release: assert property (
      (irq_pin_control[`BRF_BIT_OPEN_DRAIN] && !selected_event) ##1 irq_pin_control[`BRF_BIT_OPEN_DRAIN]
      |-> irq_pin_oe_n)
      else $error("Open-drain pad driven while idle");

   a_full_route: assert property (
      (irq_pin_control[7:2] == 6'h08 && pin_source == BRF_SRC_DATA) |-> selected_event == fifo_full)
      else $error("Full flag not routed");

   a_watermark_route: assert property (
      (irq_pin_control[4] && !irq_pin_control[2] && pin_source == BRF_SRC_DATA)
      |-> selected_event == fifo_threshold_status)
      else $error("Threshold status not routed");

   a_overrun_route: assert property (
      (irq_pin_control[5:2] == 4'h2 && pin_source == BRF_SRC_DATA) |-> selected_event == fifo_overrun)
      else $error("Overrun not routed");

   a_ready_route: assert property (
      (irq_pin_control[2] && pin_source == BRF_SRC_DATA) |-> selected_event == data_ready)
      else $error("Data-ready not routed");

   a_source_any: assert property (
      (pin_source == BRF_SRC_PRESS_ANY) |-> selected_event == (press_high_evt | press_low_evt))
      else $error("Either-event source wrong");

   a_mode_write: assert property (
      wr_fifo_ctl |=> fifo_mode == brf_fifo_mode_t'($past(reg_wdata[7:5])) && watermark_level == $past(reg_wdata[4:0]))
      else $error("FIFO control write not applied");

   a_ref_assembly: assert property (
      wr_ref_high |=> ref_pressure_value[23:16] == $past(reg_wdata))
      else $error("Reference high byte misplaced");

   a_offset_subtract: assert property (
      (!diff_irq_en && !auto_zero_en && !auto_ref_en && $stable(pressure_offset_value))
      |=> pressure_out == PRESS_W'($past(measured_pressure) - {$past(pressure_offset_value), 8'h00}))
      else $error("Offset not subtracted from pressure");

   a_threshold_level: assert property (
      (fifo_level_count >= {1'b0, watermark_level}) |=> fifo_threshold_status)
      else $error("Threshold status missing at watermark");

   a_full_level: assert property (
      (fifo_level_count == 6'h20) |=> fifo_full ##0 (fifo_level_count != 6'h20) [*1] |=> !fifo_full)
      else $error("Full flag wrong at 32 samples");

   a_flag_sticky: assert property (
      press_low_evt |=> diff_low_flag && irq_active_flag)
      else $error("Low event flag not set");

   a_boot_status: assert property (
      (flags_read && boot_running) |=> reg_rvalid && reg_rdata[7])
      else $error("Boot status not shown");

   c_open_drain_event: cover property (irq_pin_control[6] && selected_event ##1 !irq_pin_oe_n);
   c_flag_read_clear: cover property (diff_high_flag && flags_read && !press_high_evt ##1 !diff_high_flag);
   c_offset_path: cover property (pressure_offset_value != 16'h0000 && !diff_irq_en && !auto_zero_en && !auto_ref_en);
   c_fifo_full: cover property (fifo_full && fifo_threshold_status);

endmodule : brf_regs

// ---- testbench/brf_host.sv ----
/* Host model driving the byte register port of the register slice.
   Assumes strobes are sampled on the rising edge of clock. */
`timescale 1ns/1ps
module brf_host
(
   input  wire logic       clock,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   // Bus idle at time zero
   initial
   begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // One byte write, held for one sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge clock);
      #1;
      reg_wr    = 1'b0;
      reg_wdata = ~d; // Unqualified data shows the inverse, never the stale byte
   endtask : wr

   // One byte read; a missing answer returns unknowns so the caller's compare fails
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge clock);
      #1;
      reg_rd   = 1'b0;
      n        = 0;
      while (reg_rvalid !== 1'b1 && n < 4)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask : rd
endmodule : brf_host

// ---- testbench/brf_regs_tb_top.sv ----
/* Self-checking bench for the register slice: register access, pin routing, flags.
   Assumes brf_host as the register port master and a pull-up on the pin. */
`timescale 1ns/1ps
module brf_regs_tb_top;
   import brf_pkg::*;
   logic clock = 0, nrst = 0, rvalid, ovr = 0, dr = 0, hi = 0, lo = 0, boot = 0, dif = 0, az = 0, ar = 0;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd, thr, full, use_ref, lc, pin_o, pin_oe_n;
   logic [5:0] lvl = 6'h00;
   logic [4:0] wm;
   logic [23:0] meas = 24'h123456, refv, pout;
   brf_fifo_mode_t mode;
   int errors = 0, compares = 0, cyc = 0;
   wire irq_line = pin_oe_n ? 1'b1 : pin_o; // Released pad reads the pull-up
   // Pin table: config, data_ready, overrun, press_high, level, expected pin, expected enable
   localparam logic [18:0] PT [13] = '{{8'h04,3'b100,6'h00,2'b10}, {8'h84,3'b100,6'h00,2'b00},
      {8'hC4,3'b100,6'h00,2'b00}, {8'hC4,3'b000,6'h00,2'b11}, {8'h00,3'b100,6'h00,2'b00},
      {8'h10,3'b000,6'h09,2'b10}, {8'h10,3'b000,6'h08,2'b00}, {8'h08,3'b010,6'h00,2'b10},
      {8'h20,3'b000,6'h20,2'b10}, {8'h20,3'b000,6'h1F,2'b00}, {8'h01,3'b001,6'h00,2'b10},
      {8'h02,3'b001,6'h00,2'b00}, {8'h03,3'b001,6'h00,2'b10}};
   localparam logic [7:0] RA [10] = '{8'h12,8'h14,8'h15,8'h16,8'h17,8'h18,8'h19,8'h1A,8'h25,8'h30};

   brf_host u_brf_host (.clock(clock), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
      .reg_rdata(rdata), .reg_rvalid(rvalid));
   brf_regs u_brf_regs (.clock(clock), .nrst(nrst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .fifo_level_count(lvl), .fifo_overrun(ovr),
      .data_ready(dr), .press_high_evt(hi), .press_low_evt(lo), .boot_running(boot), .diff_irq_en(dif),
      .auto_zero_en(az), .auto_ref_en(ar), .measured_pressure(meas), .fifo_mode(mode),
      .watermark_level(wm), .fifo_threshold_status(thr), .fifo_full(full), .ref_pressure_value(refv),
      .use_reference(use_ref), .pressure_out(pout), .low_current_en(lc), .irq_pin_o(pin_o),
      .irq_pin_oe_n(pin_oe_n));

   // Clock at 50 MHz
   initial
   begin
      forever #10 clock = ~clock;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test();
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   // Cycle ceiling well above the fewer than two hundred cycles the sequence needs
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         stop_test();
      end
   end

   initial
   begin
      repeat (20) @(posedge clock);
      #1;
      nrst = 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         u_brf_host.rd(RA[i], d);
         chk(d, 8'h00);
      end
      for (int m = 0; m < 8; m++)
      begin
         u_brf_host.wr(8'h14, {m[2:0], 5'h09});
         chk(mode, m[2:0]);
      end
      chk(wm, 5'h09);
      for (int i = 0; i < 13; i++)
      begin
         {dr, ovr, hi, lvl} = PT[i][10:2];
         u_brf_host.wr(8'h12, PT[i][18:11]);
         repeat (3) @(posedge clock);
         #1;
         chk({irq_line, pin_oe_n}, {PT[i][1] | PT[i][0], PT[i][0]});
      end
      lvl = 6'h20;
      hi = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk({full, thr}, 2'b11);
      u_brf_host.rd(8'h25, d);
      chk(d, 8'h05);
      lo = 1'b1;
      @(posedge clock);
      #1;
      lo = 1'b0;
      u_brf_host.rd(8'h25, d);
      chk(d, 8'h06);
      boot = 1'b1;
      u_brf_host.wr(8'h25, 8'hFF);
      u_brf_host.rd(8'h25, d);
      chk(d, 8'h80);
      u_brf_host.wr(8'h15, 8'hA1);
      u_brf_host.wr(8'h16, 8'hB2);
      u_brf_host.wr(8'h17, 8'hC3);
      u_brf_host.rd(8'h16, d);
      chk({d, refv}, 32'hB2C3B2A1);
      u_brf_host.wr(8'h18, 8'h01);
      u_brf_host.wr(8'h19, 8'h13);
      repeat (3) @(posedge clock);
      #1;
      chk(pout, 24'hFF3356);
      ar = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk({use_ref, pout}, {1'b1, meas});
      ar = 1'b0;
      az = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(use_ref, 1'b1);
      // Differential path alone passes raw pressure and needs no reference
      az = 1'b0;
      dif = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk({use_ref, pout}, {1'b0, meas});
      // Low-current mode enabled here, upper bits zero and bit 0 kept
      u_brf_host.wr(8'h1A, 8'h01);
      u_brf_host.rd(8'h1A, d);
      chk({d, lc}, 9'h003);
      // Mid-run reset returns the written configuration to its defaults
      nrst = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      nrst = 1'b1;
      u_brf_host.rd(8'h12, d);
      chk({d, mode, lc}, 12'h000);
      stop_test();
   end
endmodule : brf_regs_tb_top
